// *** brownout_reset_power_control.sv ***
`timescale 1ns/1ns
module brownout_reset_power_control #(
  parameter int por_seq_cycles = brownout_pkg::por_seq_cycles_default
) (
  input wire logic clk_sys,
  input wire logic reset,
  input wire logic supply_below_por,
  input wire logic brownout_detector_trip,
  input wire logic brownout_always_on_option,
  input wire logic stop_deep,
  input wire logic soft_reset_req,
  input wire brownout_pkg::reg_req_s req,
  output logic [7:0] rdata,
  output logic sys_reset,
  output logic bo_enable,
  output logic comp_enable,
  output logic por_done
);
  import brownout_pkg::*;

  state_s cur_reg;
  state_s cur_next;
  logic bo_active;
  logic rst_hard;

  // The detector only counts when it is enabled; a disabled detector is blind
  assign bo_active = brownout_detector_trip && cur_reg.bo_enable;
  assign rst_hard = supply_below_por || bo_active;

  always_comb begin
    cur_next = cur_reg;
    cur_next.por_done = 1'b0;
    case (cur_reg.state)
      st_hold: begin
        cur_next.sys_reset = 1'b1;
        cur_next.count = '0;
        cur_next.pwr = power_control_reset;
        if (!rst_hard) begin
          cur_next.state = st_seq;
        end
      end
      st_seq: begin
        cur_next.sys_reset = 1'b1;
        cur_next.pwr = power_control_reset;
        if (rst_hard) begin
          cur_next.state = st_hold;
        end else if (cur_reg.count == 16'(por_seq_cycles - 1)) begin
          cur_next.state = st_run;
          cur_next.sys_reset = 1'b0;
          cur_next.por_done = 1'b1;
          cur_next.cause = '0;
          cur_next.cause[cause_por_bit] = 1'b1;
        end else begin
          cur_next.count = cur_reg.count + 16'h0001;
        end
      end
      st_run: begin
        cur_next.sys_reset = soft_reset_req;
        if (rst_hard) begin
          cur_next.state = st_hold;
          cur_next.sys_reset = 1'b1;
        end else if (req.wr && req.addr == power_control_zero_addr) begin
          // Reserved bits are stored as written; software keeps them legal
          cur_next.pwr = req.wdata;
        end else if (req.rd && req.addr == reset_cause_addr) begin
          cur_next.cause = '0;
        end
        if (soft_reset_req && !rst_hard) begin
          // A plain system reset leaves the power control register alone
          cur_next.cause[cause_ext_bit] = 1'b1;
        end
      end
      default: begin
        cur_next.state = st_hold;
        cur_next.sys_reset = 1'b1;
      end
    endcase
    if (!brownout_always_on_option && stop_deep) begin
      cur_next.bo_enable = 1'b0;
    end else if (!brownout_always_on_option) begin
      cur_next.bo_enable = !cur_next.pwr[brownout_disable_bit];
    end else begin
      cur_next.bo_enable = 1'b1;
    end
    cur_next.comp_enable = !cur_next.pwr[comparator_off_bit];
    if (req.rd) begin
      case (req.addr)
        power_control_zero_addr: cur_next.rdata = cur_reg.pwr;
        reset_cause_addr: cur_next.rdata = cur_reg.cause;
        default: cur_next.rdata = unmapped_read;
      endcase
    end else begin
      cur_next.rdata = unmapped_read;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (reset) begin
      cur_reg.state <= st_hold;
      cur_reg.count <= '0;
      cur_reg.pwr <= power_control_reset;
      cur_reg.cause <= '0;
      cur_reg.rdata <= unmapped_read;
      cur_reg.sys_reset <= 1'b1;
      cur_reg.bo_enable <= 1'b1;
      cur_reg.comp_enable <= 1'b1;
      cur_reg.por_done <= 1'b0;
    end else begin
      cur_reg <= cur_next;
    end
  end

  assign rdata = cur_reg.rdata;
  assign sys_reset = cur_reg.sys_reset;
  assign bo_enable = cur_reg.bo_enable;
  assign comp_enable = cur_reg.comp_enable;
  assign por_done = cur_reg.por_done;

  a_brownout_forces: assert property (@(posedge clk_sys) disable iff (reset)
    bo_active |=> sys_reset)
    else $error("brown-out did not force reset");
  a_supply_low_hold: assert property (@(posedge clk_sys) disable iff (reset)
    supply_below_por |=> sys_reset && cur_reg.state == st_hold)
    else $error("reset released while supply low");
  a_seq_full_len: assert property (@(posedge clk_sys) disable iff (reset)
    $rose(cur_reg.state == st_run) |->
      $past(cur_reg.state) == st_seq && $past(cur_reg.count) ==
      16'(por_seq_cycles - 1))
    else $error("run entered before full sequence");
  a_por_flag_set: assert property (@(posedge clk_sys) disable iff (reset)
    por_done |-> cur_reg.cause[cause_por_bit] && !sys_reset)
    else $error("power-on flag not set");
  a_recover_via_por: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_hold ##1 cur_reg.state != st_hold |->
      cur_reg.state == st_seq)
    else $error("brown-out recovery skipped power-on sequence");
  a_pwr_kept: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_run && soft_reset_req && !rst_hard && !req.wr
      |=> $stable(cur_reg.pwr))
    else $error("power control changed on plain reset");
  // The enable is registered, so the option is judged one edge later
  a_bo_enable_map: assert property (@(posedge clk_sys) disable iff (reset)
    brownout_always_on_option |=> bo_enable)
    else $error("always-on detector turned off");
  a_bo_follows_bit: assert property (@(posedge clk_sys) disable iff (reset)
    !brownout_always_on_option && !stop_deep |=>
      bo_enable == !cur_reg.pwr[brownout_disable_bit])
    else $error("detector enable does not follow bit 4");
  a_comp_follows_bit: assert property (@(posedge clk_sys) disable iff (reset)
    ##1 comp_enable == !cur_reg.pwr[comparator_off_bit])
    else $error("comparator enable does not follow bit 1");
  a_low_supply_held: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_hold |-> sys_reset)
    else $error("reset dropped in hold state");
  a_seq_holds_reset: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_seq |-> sys_reset)
    else $error("reset dropped during power-on sequence");
  a_por_only_from_seq: assert property (@(posedge clk_sys) disable iff (reset)
    por_done |-> $past(cur_reg.state) == st_seq)
    else $error("power-on flag pulsed outside the sequence");
  a_soft_cause_set: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_run && soft_reset_req && !rst_hard
      |=> cur_reg.cause[cause_ext_bit])
    else $error("plain reset cause not recorded");
  a_stop_bo_off: assert property (@(posedge clk_sys) disable iff (reset)
    !brownout_always_on_option && stop_deep |=> !bo_enable)
    else $error("detector left on in stop");
  a_write_effect: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_run && !rst_hard && req.wr &&
      req.addr == power_control_zero_addr |=>
      comp_enable == !$past(req.wdata[comparator_off_bit]) &&
      (brownout_always_on_option || stop_deep ||
       bo_enable == !$past(req.wdata[brownout_disable_bit])))
    else $error("enables did not follow write");
  a_pwr_reset_val: assert property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_seq |-> cur_reg.pwr == power_control_reset)
    else $error("power control not at reset value");

  c_por_done: cover property (@(posedge clk_sys) disable iff (reset) por_done);
  c_brownout: cover property (@(posedge clk_sys) disable iff (reset)
    cur_reg.state == st_run ##1 cur_reg.state == st_hold);
  c_pwr_write: cover property (@(posedge clk_sys) disable iff (reset)
    req.wr && req.addr == power_control_zero_addr && cur_reg.state == st_run);
  c_stop: cover property (@(posedge clk_sys) disable iff (reset)
    stop_deep && !bo_enable);
endmodule : brownout_reset_power_control

// *** brownout_pkg.sv ***
// What this block does
// - A brown-out report from the detector forces the whole chip into reset.
// - While the supply is below the power-on threshold, system reset stays on.
// - When the supply rises again, the full power-on reset sequence runs first.
// - When that sequence completes, the power-on flag of the cause register is set.
// - Recovery from brown-out always goes through a full power-on reset.
// - The power control register resets only during a power-on reset sequence.
// - Bit 4 disables the brown-out detector when one, enables it when zero.
// - Bit 4 acts only when the always-on option is off; else detector stays on.
// - In the deepest stop state the detector is off unless always-on is set.
// - Bit 1 turns the comparator off when one, keeps it running when zero.
// - The power control register resets to bits 7 and 3 set, all others clear.
package brownout_pkg;
  localparam logic [11:0] power_control_zero_addr = 12'hf80;
  localparam logic [11:0] reset_cause_addr = 12'hf81;
  localparam logic [7:0] power_control_reset = 8'h88;
  localparam int brownout_disable_bit = 4;
  localparam int comparator_off_bit = 1;
  localparam int cause_por_bit = 7;
  localparam int cause_ext_bit = 4;
  localparam int por_seq_cycles_default = 64;
  localparam logic [7:0] unmapped_read = 8'h00;

  typedef enum logic [2:0] {
    st_hold = 3'b001,
    st_seq = 3'b010,
    st_run = 3'b100
  } seq_state_e;

  typedef struct packed {
    logic [11:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_s;

  typedef struct packed {
    seq_state_e state;
    logic [15:0] count;
    logic [7:0] pwr;
    logic [7:0] cause;
    logic [7:0] rdata;
    logic sys_reset;
    logic bo_enable;
    logic comp_enable;
    logic por_done;
  } state_s;
endpackage : brownout_pkg

// *** tb_brownout_reset_power_control.sv ***
`timescale 1ns/1ns
module tb_brownout_reset_power_control;
  import brownout_pkg::*;
  logic clk_sys = 1'b0;
  logic reset = 1'b1;
  logic supply_below_por = 1'b0;
  logic brownout_detector_trip = 1'b0;
  logic brownout_always_on_option = 1'b0;
  logic stop_deep = 1'b0;
  logic soft_reset_req = 1'b0;
  reg_req_s req = '0;
  logic [7:0] rdata;
  logic sys_reset;
  logic bo_enable;
  logic comp_enable;
  logic por_done;
  logic [7:0] got;
  int fails = 0;
  int samples_checked = 0;
  always #4 clk_sys = ~clk_sys;
  // Short sequence keeps each power-on recovery to a few cycles
  brownout_reset_power_control #(.por_seq_cycles(4)) brownout_reset_power_control_inst (
    .clk_sys(clk_sys), .reset(reset), .supply_below_por(supply_below_por),
    .brownout_detector_trip(brownout_detector_trip),
    .brownout_always_on_option(brownout_always_on_option),
    .stop_deep(stop_deep), .soft_reset_req(soft_reset_req), .req(req),
    .rdata(rdata), .sys_reset(sys_reset), .bo_enable(bo_enable),
    .comp_enable(comp_enable), .por_done(por_done));
  task check(input logic [7:0] seen, input logic [7:0] want);
    samples_checked++;
    if (seen !== want) begin
      fails++;
      $display("ERROR at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask : check
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk_sys);
    req.wr <= 1'b0;
    #1;
  endtask : wr
  task rd(input logic [11:0] a, output logic [7:0] d);
    @(posedge clk_sys);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_sys);
    req.rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd
  task cycles(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : cycles
  // Bounded wait: a sequence that never ends shows up as a missing pulse
  task wait_por;
    int n;
    n = 0;
    while (por_done !== 1'b1 && n < 200) begin
      cycles(1);
      n++;
    end
    check({7'h00, por_done}, 8'h01);
    cycles(1);
    check({7'h00, sys_reset}, 8'h00);
  endtask : wait_por
  task t_power_on;
    wait_por();
    rd(power_control_zero_addr, got);
    check(got, 8'h88);
    rd(reset_cause_addr, got);
    check(got & 8'h80, 8'h80);
    check({6'h00, bo_enable, comp_enable}, 8'h03);
    $display("power-on test done");
  endtask : t_power_on
  task t_bits;
    wr(power_control_zero_addr, 8'h0a);
    check({6'h00, bo_enable, comp_enable}, 8'h02);
    wr(power_control_zero_addr, 8'h18);
    check({6'h00, bo_enable, comp_enable}, 8'h01);
    rd(power_control_zero_addr, got);
    check(got, 8'h18);
    brownout_always_on_option <= 1'b1;
    cycles(2);
    check({7'h00, bo_enable}, 8'h01);
    brownout_always_on_option <= 1'b0;
    wr(power_control_zero_addr, 8'h08);
    stop_deep <= 1'b1;
    cycles(2);
    check({7'h00, bo_enable}, 8'h00);
    stop_deep <= 1'b0;
    rd(12'hf82, got);
    check(got, unmapped_read);
    $display("register bits test done");
  endtask : t_bits
  task t_soft;
    int n;
    wr(power_control_zero_addr, 8'h0a);
    soft_reset_req <= 1'b1;
    cycles(1);
    // Plain reset follows the request by one edge and drops with it
    check({7'h00, sys_reset}, 8'h01);
    soft_reset_req <= 1'b0;
    cycles(1);
    n = 0;
    while (sys_reset !== 1'b0 && n < 200) begin
      cycles(1);
      n++;
    end
    rd(power_control_zero_addr, got);
    check(got, 8'h0a);
    rd(reset_cause_addr, got);
    check(got & 8'h10, 8'h10);
    $display("soft reset test done");
  endtask : t_soft
  task t_brownout;
    brownout_detector_trip <= 1'b1;
    supply_below_por <= 1'b1;
    cycles(2);
    check({7'h00, sys_reset}, 8'h01);
    brownout_detector_trip <= 1'b0;
    for (int i = 0; i < 6; i++) begin
      cycles(1);
      check({7'h00, sys_reset}, 8'h01);
    end
    supply_below_por <= 1'b0;
    wait_por();
    rd(power_control_zero_addr, got);
    check(got, 8'h88);
    check({7'h00, comp_enable}, 8'h01);
    $display("brown-out test done");
  endtask : t_brownout
  task tally_and_finish;
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    cycles(5);
    reset <= 1'b0;
    t_power_on();
    t_bits();
    t_soft();
    t_brownout();
    tally_and_finish();
  end
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end
endmodule : tb_brownout_reset_power_control
